// ===== include/buck_ctrl_pkg.sv
// constants for the step-down switch and protection sequencer
package buck_ctrl_pkg;
   localparam int CLK_MHZ = 200;
   localparam int TON_MIN_NS = 60;
   localparam int TOFF_MIN_NS = 100;
   localparam int BLANK_NS = 40;
   localparam int DEAD_NS = 10;
   localparam int PERIOD_NS = 475;
   localparam int HICCUP_MS = 5;
   localparam int TON_MIN_CYC = (TON_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int TOFF_MIN_CYC = (TOFF_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int PERIOD_CYC = (PERIOD_NS * CLK_MHZ) / 1000;
   localparam int HICCUP_CYC = HICCUP_MS * CLK_MHZ * 1000;
   localparam int OC_LIMIT = 64;
   // register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
   localparam logic [11:0] IRQ_EN_OFS = 12'h00C;
   localparam logic [11:0] IRQ_CLR_OFS = 12'h010;
   localparam logic [11:0] OC_CNT_OFS = 12'h014;
   // ctrl fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_FFF_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // event bits
   localparam int EV_HICCUP = 0;
   localparam int EV_THERMAL = 1;
   localparam int EV_UNDERVOLTAGE_LOCKOUT = 2;
   localparam int EV_NEG = 3;
   localparam int EV_VALLEY = 4;
   localparam int EV_W = 5;
   typedef enum logic [2:0] {st_off, st_upper, st_dead_lo, st_lower, st_dead_hi, st_hiccup} phase_t;
endpackage : buck_ctrl_pkg

// ===== logic/buck_switch_protection_control.sv
// switch sequencing, current limits, hiccup and thermal shutdown for a step-down converter
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Function
// - both switches off until bias rail comparator reports above lockout threshold
// - lockout re-entry uses the lower comparator, 400 mV below rising level
// - upper switch stays on at least minimum on-time once turned on
// - upper switch stays off at least minimum off-time before next turn-on
// - at maximum duty, stretch the period so a larger duty is reached
// - peak comparator ignored during blanking after upper switch turns on
// - constant peak clamp ends the on-time in that cycle
// - valley overcurrent at cycle end keeps lower on, withholds next pulse
// - once below valley limit, lower off then upper on after dead time
// - 64 consecutive valley overcurrent cycles start hiccup protection
// - hiccup keeps both switches off for 5 ms then restarts
// - persistent fault repeats the hiccup and retry loop
// - forced fixed-frequency: negative limit turns lower off until next cycle
// - over-temperature above 170 C turns the converter off
// - below 155 C restart the full power-up sequence with soft start
// - bootstrap recharge only while upper is off and lower conducts
// - lower switch turns on only after dead time following upper turn-off
module buck_switch_protection_control
   import buck_ctrl_pkg::*;
#(
   parameter int hiccup_cycles = HICCUP_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bias_above_rise,
   input wire logic bias_above_fall,
   input wire logic temp_above_shutdown,
   input wire logic temp_above_restart,
   input wire logic peak_compare_trip,
   input wire logic upper_peak_current_clamp,
   input wire logic lower_valley_current_limit,
   input wire logic negative_current_limit,
   output logic upper_switch,
   output logic lower_switch,
   output logic boot_refresh,
   output logic soft_start,
   output logic irq
);
   // three-stage synchronisers; stage 1 is read only by stage 2
   logic [7:0] sync1, sync2, sync3, pin;
   logic [7:0] raw;
   assign raw = {negative_current_limit, lower_valley_current_limit, upper_peak_current_clamp,
                 peak_compare_trip, temp_above_restart, temp_above_shutdown, bias_above_fall, bias_above_rise};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
         sync3 <= 8'h00;
      end
      else
      begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pin
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               pin[gi] <= 1'b0;
            else if (sync2[gi] == sync3[gi])
               pin[gi] <= sync3[gi];
         end
      end
   endgenerate
   logic rail_rise, rail_fall, hot, warm, peak_trip, clamp_trip, valley_oc, neg_oc;
   assign {neg_oc, valley_oc, clamp_trip, peak_trip, warm, hot, rail_fall, rail_rise} = pin;

   // registers
   logic [1:0] ctrl;
   logic [EV_W-1:0] irq_stat, irq_en, ev;
   logic [6:0] oc_count;
   phase_t phase;
   logic rail_ok, thermal_off;
   logic wr_en, rd_en;
   assign wr_en = psel && penable && pwrite;
   // read data captured in the setup cycle so it stands through the zero-wait access phase
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   logic addr_ok;
   assign addr_ok = paddr == CTRL_OFS || paddr == STATUS_OFS || paddr == IRQ_STAT_OFS ||
                    paddr == IRQ_EN_OFS || paddr == IRQ_CLR_OFS || paddr == OC_CNT_OFS;
   assign pslverr = psel && penable && !addr_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl <= CTRL_RESET;
      else if (wr_en && paddr == CTRL_OFS)
         ctrl <= pwdata[1:0];
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_en <= '0;
      else if (wr_en && paddr == IRQ_EN_OFS)
         irq_en <= pwdata[EV_W-1:0];
   end
   // set wins over a simultaneous clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat <= '0;
      else if (wr_en && paddr == IRQ_CLR_OFS)
         irq_stat <= (irq_stat & ~pwdata[EV_W-1:0]) | ev;
      else
         irq_stat <= irq_stat | ev;
   end
   assign irq = |(irq_stat & irq_en);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en)
      begin
         unique case (paddr)
            CTRL_OFS: prdata <= {30'h0, ctrl};
            STATUS_OFS: prdata <= {26'h0, thermal_off, rail_ok, 1'b0, phase};
            IRQ_STAT_OFS: prdata <= {27'h0, irq_stat};
            IRQ_EN_OFS: prdata <= {27'h0, irq_en};
            OC_CNT_OFS: prdata <= {25'h0, oc_count};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // bias rail lockout with hysteresis: on via rise comparator, off only via lower one
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rail_ok <= 1'b0;
      else if (!rail_fall)
         rail_ok <= 1'b0;
      else if (rail_rise)
         rail_ok <= 1'b1;
   end
   // thermal latch, released only at the lower trip point
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         thermal_off <= 1'b0;
      else if (hot)
         thermal_off <= 1'b1;
      else if (!warm)
         thermal_off <= 1'b0;
   end
   logic run;
   assign run = rail_ok && !thermal_off && ctrl[CTRL_ENABLE_BIT];

   // switching period oscillator; stretched while upper is still held on
   logic [15:0] per_cnt, on_cnt, off_cnt;
   logic [31:0] hic_cnt;
   logic cycle_end;
   assign cycle_end = per_cnt >= 16'(PERIOD_CYC - 1);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         per_cnt <= 16'h0000;
      else if (phase == st_off || phase == st_hiccup)
         per_cnt <= 16'h0000;
      else if (cycle_end && phase != st_upper)
         per_cnt <= 16'h0000;
      else if (!cycle_end)
         per_cnt <= per_cnt + 16'h0001;
   end

   logic upper_may_end, cycle_start;
   // peak comparator counts only after blanking and minimum on-time
   assign upper_may_end = on_cnt >= 16'(TON_MIN_CYC) && on_cnt >= 16'(BLANK_CYC);
   assign cycle_start = cycle_end && phase != st_upper;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         on_cnt <= 16'h0000;
      else if (phase == st_upper)
         on_cnt <= on_cnt + 16'h0001;
      else
         on_cnt <= 16'h0000;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         off_cnt <= 16'h0000;
      else if (phase == st_upper)
         off_cnt <= 16'h0000;
      else if (off_cnt != 16'hFFFF)
         off_cnt <= off_cnt + 16'h0001;
   end

   logic [15:0] dead_cnt;
   logic neg_hold;
   logic valley_held;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase <= st_off;
      else if (!run)
         phase <= st_off;
      else
      begin
         unique case (phase)
            st_off: phase <= st_dead_hi;
            st_upper:
               // maximum duty means on until both minimum on-time and blanking have passed and the comparator trips
               if (upper_may_end && (peak_trip || clamp_trip))
                  phase <= st_dead_lo;
            st_dead_lo:
               if (dead_cnt >= 16'(DEAD_CYC - 1))
                  phase <= st_lower;
            st_lower:
               if (oc_count >= 7'(OC_LIMIT))
                  phase <= st_hiccup;
               else if (!valley_oc && (cycle_start || valley_held))
                  phase <= st_dead_hi;
            st_dead_hi:
               if (dead_cnt >= 16'(DEAD_CYC - 1) && off_cnt >= 16'(TOFF_MIN_CYC))
                  phase <= st_upper;
            st_hiccup:
               if (hic_cnt >= 32'(hiccup_cycles - 1))
                  phase <= st_off;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dead_cnt <= 16'h0000;
      else if (phase == st_dead_lo || phase == st_dead_hi)
         dead_cnt <= dead_cnt + 16'h0001;
      else
         dead_cnt <= 16'h0000;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hic_cnt <= 32'h0000_0000;
      else if (phase == st_hiccup)
         hic_cnt <= hic_cnt + 32'h0000_0001;
      else
         hic_cnt <= 32'h0000_0000;
   end
   // consecutive valley overcurrent cycles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         oc_count <= 7'h00;
      else if (phase == st_off || phase == st_hiccup)
         oc_count <= 7'h00;
      else if (cycle_start && phase == st_lower)
      begin
         if (valley_oc)
            oc_count <= oc_count + 7'h01;
         else
            oc_count <= 7'h00;
      end
   end
   // negative limit holds lower off until the next period begins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         neg_hold <= 1'b0;
      else if (phase != st_lower || cycle_start)
         neg_hold <= 1'b0;
      else if (ctrl[CTRL_FFF_BIT] && neg_oc)
         neg_hold <= 1'b1;
   end
   // lower held past a period end; released as soon as the valley clears, not a period later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         valley_held <= 1'b0;
      else if (phase != st_lower)
         valley_held <= 1'b0;
      else if (cycle_start && valley_oc)
         valley_held <= 1'b1;
   end
   // soft start requested on each fresh start from off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         soft_start <= 1'b0;
      else
         soft_start <= run && phase == st_off;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         upper_switch <= 1'b0;
         lower_switch <= 1'b0;
         boot_refresh <= 1'b0;
      end
      else
      begin
         upper_switch <= run && phase == st_upper;
         lower_switch <= run && phase == st_lower && !(neg_hold || (ctrl[CTRL_FFF_BIT] && neg_oc));
         boot_refresh <= run && phase == st_lower && !(neg_hold || (ctrl[CTRL_FFF_BIT] && neg_oc));
      end
   end
   logic rail_ok_d, thermal_d;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rail_ok_d <= 1'b0;
         thermal_d <= 1'b0;
      end
      else
      begin
         rail_ok_d <= rail_ok;
         thermal_d <= thermal_off;
      end
   end
   always_comb
   begin
      ev = '0;
      ev[EV_HICCUP] = phase == st_lower && run && oc_count >= 7'(OC_LIMIT);
      ev[EV_THERMAL] = thermal_off && !thermal_d;
      ev[EV_UNDERVOLTAGE_LOCKOUT] = rail_ok_d && !rail_ok;
      ev[EV_NEG] = ctrl[CTRL_FFF_BIT] && neg_oc && phase == st_lower && !neg_hold;
      ev[EV_VALLEY] = cycle_start && phase == st_lower && valley_oc;
   end
endmodule : buck_switch_protection_control

// ===== bench/buck_ctrl_assertions.sv
// port checker for the step-down switch sequencer
`timescale 1ns/1ps
module buck_ctrl_assertions
   import buck_ctrl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pslverr,
   input wire logic bias_above_rise,
   input wire logic bias_above_fall,
   input wire logic temp_above_shutdown,
   input wire logic lower_valley_current_limit,
   input wire logic upper_switch,
   input wire logic lower_switch,
   input wire logic boot_refresh
);
   int on_len;
   int off_len;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // run lengths of the upper switch, in clocks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         on_len <= 0;
         off_len <= 0;
      end
      else
      begin
         on_len <= upper_switch ? on_len + 1 : 0;
         off_len <= upper_switch ? 0 : off_len + 1;
      end
   end
   no_overlap_a: assert property (!(upper_switch && lower_switch)) else $error("switch overlap");
   lockout_off_a: assert property ((!bias_above_rise && !bias_above_fall) [*8]
      |-> !upper_switch && !lower_switch) else $error("switching in lockout");
   thermal_off_a: assert property (temp_above_shutdown [*8]
      |-> !upper_switch && !lower_switch) else $error("switching when hot");
   // a fault kill may cut a pulse short, so those are left out
   min_on_a: assert property ($fell(upper_switch) && bias_above_fall && !temp_above_shutdown
      |-> on_len >= TON_MIN_CYC) else $error("on-time short");
   min_off_a: assert property ($rose(upper_switch) |-> off_len >= TOFF_MIN_CYC) else $error("off-time short");
   dead_low_a: assert property ($fell(upper_switch) |-> !lower_switch [*2]) else $error("no dead time low");
   dead_high_a: assert property ($fell(lower_switch) |-> !upper_switch [*2]) else $error("no dead time high");
   boot_window_a: assert property (boot_refresh |-> lower_switch && !upper_switch) else $error("bad refresh");
   valley_hold_a: assert property ((lower_switch && lower_valley_current_limit) [*8]
      |=> !upper_switch [*3]) else $error("pulse in valley fault");
   unmapped_err_a: assert property (psel && penable && paddr > OC_CNT_OFS |-> pslverr) else $error("no slverr");
endmodule : buck_ctrl_assertions

// ===== bench/power_stage_model.sv
// inductor current and comparator model of the power stage
`timescale 1ns/1ps
module power_stage_model
(
   input wire logic pclk,
   input wire logic upper_switch,
   input wire logic lower_switch,
   input wire logic short_out,
   input int slope_up,
   input int peak_cmd,
   input int neg_lvl,
   output logic peak_compare_trip,
   output logic upper_peak_current_clamp,
   output logic lower_valley_current_limit,
   output logic negative_current_limit
);
   localparam int CLAMP_LVL = 400;
   localparam int VALLEY_LVL = 600;
   localparam int SLOPE_DN = 2;
   int coil = 0;
   // with both off the body diode drains the coil to zero
   always @(posedge pclk)
   begin
      if (upper_switch)
         coil <= coil + slope_up;
      else if (lower_switch)
         coil <= coil - SLOPE_DN;
      else
         coil <= (coil > 0) ? coil - SLOPE_DN : 0;
   end
   assign peak_compare_trip = coil >= peak_cmd;
   assign upper_peak_current_clamp = coil >= CLAMP_LVL;
   assign lower_valley_current_limit = short_out || coil > VALLEY_LVL;
   assign negative_current_limit = coil < -neg_lvl;
endmodule : power_stage_model

// ===== bench/tb_top.sv
// self-checking bench for the step-down switch sequencer
`timescale 1ns/1ps
module tb_top
   import buck_ctrl_pkg::*;
;
   localparam int HIC = 200;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, short_out = 0, up_q = 0;
   logic bias_above_rise = 0, bias_above_fall = 0, temp_above_shutdown = 0, temp_above_restart = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, seed = 32'h4552826C;
   logic pready, pslverr, err, peak_compare_trip, upper_peak_current_clamp, lower_valley_current_limit;
   logic negative_current_limit, upper_switch, lower_switch, boot_refresh, soft_start, irq;
   int slope_up = 10, peak_cmd = 200, neg_lvl = 1000000, errors = 0, cmp_count = 0, cyc = 0;
   int rise_n = 0, on_n = 0, per_n = 0, on_c = 0, per_c = 0, neg_c = 0, fff = 0, ss_n = 0, r, c;
   buck_switch_protection_control #(.hiccup_cycles(HIC)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .bias_above_rise, .bias_above_fall, .temp_above_shutdown,
      .temp_above_restart, .peak_compare_trip, .upper_peak_current_clamp, .lower_valley_current_limit,
      .negative_current_limit, .upper_switch, .lower_switch, .boot_refresh, .soft_start, .irq);
   power_stage_model stage (.pclk, .upper_switch, .lower_switch, .short_out, .slope_up, .peak_cmd, .neg_lvl,
      .peak_compare_trip, .upper_peak_current_clamp, .lower_valley_current_limit, .negative_current_limit);
   initial
   begin
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task tally_and_finish;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // read data stands from the setup edge on; taken with pready at the access edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      err = pslverr;
      rd = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task automatic wait_rise(input int n);
      int r0;
      r0 = rise_n;
      wait (rise_n >= r0 + n);
   endtask : wait_rise
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         tally_and_finish;
      end
      per_c++;
      ss_n += soft_start;
      on_c += upper_switch;
      neg_c = negative_current_limit ? neg_c + 1 : 0;
      if (fff && lower_switch && neg_c > 6)
         chk("neg off", 0, lower_switch);
      if (upper_switch && !up_q)
      begin
         rise_n++;
         per_n = per_c;
         per_c = 0;
      end
      if (!upper_switch && up_q)
      begin
         on_n = on_c;
         on_c = 0;
      end
      up_q = upper_switch;
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk("switches", 0, {upper_switch, lower_switch});
      apb(0, CTRL_OFS, 0);
      chk("ctrl", CTRL_RESET, rd);
      apb(1, CTRL_OFS, 1);
      apb(0, CTRL_OFS, 0);
      chk("ctrl", 1, rd);
      apb(0, 12'h020, 0);
      chk("slverr", 1, err);
      apb(1, IRQ_EN_OFS, 1);
      repeat (50) @(posedge pclk);
      chk("rises", 0, rise_n);
      bias_above_rise <= 1;
      bias_above_fall <= 1;
      wait_rise(3);
      chk("period", PERIOD_CYC, per_n);
      bias_above_rise <= 0;
      wait_rise(2);
      bias_above_fall <= 0;
      repeat (20) @(posedge pclk);
      r = rise_n;
      apb(0, STATUS_OFS, 0);
      chk("rail ok", 0, rd & 32'h10);
      chk("rises", r, rise_n);
      bias_above_rise <= 1;
      bias_above_fall <= 1;
      slope_up <= 1;
      peak_cmd <= 100000;
      temp_above_shutdown <= 1;
      temp_above_restart <= 1;
      repeat (30) @(posedge pclk);
      r = rise_n;
      apb(0, STATUS_OFS, 0);
      chk("thermal", 32'h20, rd & 32'h20);
      temp_above_shutdown <= 0;
      repeat (100) @(posedge pclk);
      chk("rises", r, rise_n);
      c = ss_n;
      temp_above_restart <= 0;
      wait_rise(1);
      chk("soft start", c + 1, ss_n);
      wait_rise(1);
      chk("foldback", 1, per_n > PERIOD_CYC);
      slope_up <= 10;
      wait_rise(4);
      chk("clamp", 1, on_n <= 48);
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         peak_cmd <= (k == 0) ? 0 : 40 + seed % 160;
         wait_rise(4);
         chk("period", PERIOD_CYC, per_n);
      end
      fff = 1;
      apb(1, CTRL_OFS, 3);
      peak_cmd <= 60;
      neg_lvl <= 10;
      wait_rise(4);
      apb(0, IRQ_STAT_OFS, 0);
      chk("neg event", 32'h8, rd & 32'h8);
      fff = 0;
      neg_lvl <= 1000000;
      peak_cmd <= 200;
      apb(1, CTRL_OFS, 1);
      apb(1, IRQ_CLR_OFS, 32'h1F);
      c = cyc;
      short_out <= 1;
      wait (irq === 1'b1);
      chk("oc cycles", 1, cyc - c >= (OC_LIMIT - 1) * PERIOD_CYC);
      chk("oc cycles max", 1, cyc - c <= (OC_LIMIT + 2) * PERIOD_CYC);
      r = rise_n;
      c = cyc;
      wait (rise_n != r);
      chk("hiccup off", 1, cyc - c >= HIC - 2);
      chk("hiccup max", 1, cyc - c <= HIC + 10);
      apb(1, IRQ_CLR_OFS, 1);
      chk("irq clear", 0, irq);
      wait (irq === 1'b1);
      apb(1, IRQ_EN_OFS, 0);
      chk("irq mask", 0, irq);
      short_out <= 0;
      wait_rise(6);
      apb(0, OC_CNT_OFS, 0);
      chk("oc count", 0, rd);
      short_out <= 1;
      repeat (10 * PERIOD_CYC) @(posedge pclk);
      apb(0, OC_CNT_OFS, 0);
      chk("oc count held", 1, rd != 0);
      short_out <= 0;
      wait_rise(3);
      apb(0, OC_CNT_OFS, 0);
      chk("oc count clean", 0, rd);
      tally_and_finish;
   end
endmodule : tb_top
bind buck_switch_protection_control buck_ctrl_assertions chk_i (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
   .bias_above_rise, .bias_above_fall, .temp_above_shutdown, .lower_valley_current_limit, .upper_switch,
   .lower_switch, .boot_refresh);
